// ### irqds_pkg.sv
// Package: constants for the interrupt and DMA resource routing block
package irqds_pkg;

	// Logical device count and numbers
	localparam int          NUM_DEV        = 8;    // Device number space 0..7
	localparam logic [2:0]  DEV_FLOPPY     = 3'h0; // Floppy controller
	localparam logic [2:0]  DEV_PARALLEL   = 3'h3; // Parallel port unit
	localparam logic [2:0]  DEV_SERIAL1    = 3'h4; // First serial port
	localparam logic [2:0]  DEV_SERIAL2    = 3'h5; // Second serial port
	localparam logic [2:0]  DEV_KEYBOARD   = 3'h7; // Keyboard controller unit

	// Global configuration indexes
	localparam logic [7:0]  IDX_DEV_NUM    = 8'h07; // Logical device number
	localparam logic [7:0]  IDX_POWER_CTRL = 8'h22; // Power control bit per device
	localparam logic [7:0]  IDX_OSC_CFG    = 8'h24; // Global oscillator config
	localparam logic [7:0]  IDX_PORT_LOW   = 8'h26; // Config port address low
	localparam logic [7:0]  IDX_PORT_HIGH  = 8'h27; // Config port address high

	// Per-device configuration indexes
	localparam logic [7:0]  IDX_ACTIVATE   = 8'h30; // Activate bit
	localparam logic [7:0]  IDX_BASE_HIGH  = 8'h60; // Base address high byte
	localparam logic [7:0]  IDX_BASE_LOW   = 8'h61; // Base address low byte
	localparam logic [7:0]  IDX_IRQ_SEL    = 8'h70; // interrupt_line_select
	localparam logic [7:0]  IDX_DMA_SEL    = 8'h74; // dma_channel_choice

	// Field positions
	localparam int          OSC_QUAL16_BIT = 6; // 16-bit address qualify

	// Reset values
	localparam logic [7:0]  IRQ_SEL_RST_FLOPPY = 8'h06;    // Floppy interrupt select
	localparam logic [7:0]  IRQ_SEL_RST_OTHER  = 8'h00;    // Other devices
	localparam logic [7:0]  DMA_SEL_RST_FLOPPY = 8'h02;    // Floppy DMA select
	localparam logic [7:0]  DMA_SEL_RST_PAR    = 8'h04;    // Devices 1 to 7
	localparam logic [7:0]  DMA_SEL_RST_OTHER  = 8'h04;    // No DMA active
	localparam logic [15:0] PORT_ADDR_STRAP0   = 16'h002E; // Strap low
	localparam logic [15:0] PORT_ADDR_STRAP1   = 16'h004E; // Strap high
	localparam logic [7:0]  OSC_CFG_RST        = 8'h00;    // Oscillator config

	// Address ranges
	localparam logic [15:0] PORT_RANGE_LO  = 16'h0100; // Config port lowest
	localparam logic [15:0] PORT_RANGE_HI  = 16'h0FFE; // Config port highest
	localparam logic [15:0] BASE_RANGE_LO  = 16'h0100; // Device base lowest
	localparam logic [15:0] BASE_RANGE_HI  = 16'h0FF8; // Device base highest

	// Selection encodings
	localparam logic [3:0]  IRQ_NONE       = 4'h0; // No interrupt
	localparam logic [3:0]  IRQ_SHARED_SMI = 4'h2; // Shared with management irq
	localparam logic [2:0]  DMA_CH_FIRST   = 3'h1; // Lowest active channel
	localparam logic [2:0]  DMA_CH_LAST    = 3'h3; // Highest active channel

	// Parallel extended mode codes with interrupt on unless service bit D2 is set
	localparam logic [2:0]  ECR_MODE_FIFO  = 3'h2; // FIFO mode
	localparam logic [2:0]  ECR_MODE_ECP   = 3'h3; // Extended capability
	localparam logic [2:0]  ECR_MODE_TEST  = 3'h6; // Test mode

endpackage : irqds_pkg

// ### irqds_route_if.sv
// Interface: per-device selections and qualified requests for the router
`timescale 1ns/1ps
`default_nettype none
interface irqds_route_if;
	logic [3:0]  irqSel  [0:7];   // Interrupt line per device
	logic [2:0]  dmaSel  [0:7];   // DMA channel per device
	logic [7:0]  irqQual;         // Qualified interrupt requests
	logic [7:0]  dmaQual;         // Qualified DMA requests
	logic [15:1] irqLines;        // Combined interrupt lines
	logic [3:1]  dmaLines;        // Combined DMA requests

	modport ctrl  (output irqSel, output dmaSel, output irqQual, output dmaQual,
		input irqLines, input dmaLines);
	modport route (input irqSel, input dmaSel, input irqQual, input dmaQual,
		output irqLines, output dmaLines);
endinterface : irqds_route_if
`default_nettype wire

// ### irqds_router.sv
// Module: combines qualified device requests onto interrupt and DMA lines
`timescale 1ns/1ps
`default_nettype none
module irqds_router (
	input  wire logic       clk_sys,   // System clock
	input  wire logic       rst_n,     // Async reset, active low
	irqds_route_if.route    rt         // Selections and requests
);

	logic [15:1] next_irqLines;   // Combined interrupt levels
	logic [3:1]  next_dmaLines;   // Combined DMA levels

	// OR every device that picked a line; unselected lines stay low
	always_comb begin
		next_irqLines = '0;
		next_dmaLines = '0;
		for (int d = 0; d < irqds_pkg::NUM_DEV; d++) begin
			for (int n = 1; n <= 15; n++) begin
				if (rt.irqQual[d] && (rt.irqSel[d] == 4'(n))) begin
					next_irqLines[n] = 1'b1;
				end
			end
			for (int c = 1; c <= 3; c++) begin
				if (rt.dmaQual[d] && (rt.dmaSel[d] == 3'(c))) begin
					next_dmaLines[c] = 1'b1;
				end
			end
		end
	end

	// Registered so lines never glitch while selections change
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			rt.irqLines <= '0;
			rt.dmaLines <= '0;
		end else begin
			rt.irqLines <= next_irqLines;
			rt.dmaLines <= next_dmaLines;
		end
	end

endmodule : irqds_router
`default_nettype wire

// ### irqds_top.sv
// Module: configuration port, per-device resource selects and request gating
`timescale 1ns/1ps
`default_nettype none
module irqds_top (
	input  wire logic        clk_sys,                 // System clock, 10 MHz
	input  wire logic        rst_n,                   // Power-on reset, active low
	input  wire logic        hardReset,               // Hard reset pulse
	input  wire logic        softReset,               // Soft reset pulse
	input  wire logic        config_port_strap,       // Strap pin, asynchronous
	input  wire logic [15:0] ioAddr,                  // Host I/O address
	input  wire logic [7:0]  ioWrData,                // Host write data
	input  wire logic        ioWr,                    // Host write strobe
	input  wire logic        ioRd,                    // Host read strobe
	output logic      [7:0]  ioRdData,                // Host read data
	output logic             ioRdHit,                 // Read claimed by config port
	input  wire logic        floppy_dma_irq_enable,   // Floppy output reg bit D3
	input  wire logic        floppyPowerDown,         // Floppy powered down
	input  wire logic        floppyIrqReq,            // Floppy interrupt request
	input  wire logic        floppyDmaReq,            // Floppy DMA request
	input  wire logic        parallel_irq_enable,     // Parallel control bit D4
	input  wire logic        parallelEcpMode,         // Parallel in extended mode
	input  wire logic [2:0]  parallelEcrMode,         // Extended mode code
	input  wire logic        ecp_service_irq_bit,     // Extended control bit D2
	input  wire logic        ecp_dma_enable_bit,      // Extended control bit D3
	input  wire logic        parallelIrqReq,          // Parallel interrupt request
	input  wire logic        parallel_dma_request,    // Parallel DMA request
	input  wire logic [3:0]  uartIrqEnable1,          // Serial 1 enable bits D0-D3
	input  wire logic [3:0]  uartIrqEnable2,          // Serial 2 enable bits D0-D3
	input  wire logic [1:0]  uart_aux_output_second,  // Modem control D2 per port
	input  wire logic [1:0]  serialIrqReq,            // Serial interrupt requests
	input  wire logic        kbdIrqReq,               // Keyboard interrupt request
	input  wire logic        smiReq,                  // Management interrupt event
	output logic      [15:1] irqLines,                // Interrupt lines, active high
	output logic             system_mgmt_irq_n,       // Management interrupt, active low
	output logic      [3:1]  dmaLines                 // DMA requests per channel
);

	// Configuration state
	logic [7:0]  indexReg;               // Config index register
	logic [2:0]  devNum;                 // Selected logical device
	logic [15:0] portAddr;               // Config port address
	logic [7:0]  oscCfg;                 // Global oscillator config
	logic [7:0]  devOn;                  // Linked activate and power bits
	logic [15:0] baseAddr [0:7];         // Device base addresses
	logic [7:0]  irqSelReg [0:7];        // interrupt_line_select per device
	logic [7:0]  dmaSelReg [0:7];        // dma_channel_choice per device
	logic        strapMeta;              // Strap sync stage 1
	logic        strapSync;              // Strap sync stage 2
	logic [1:0]  strapWait;              // Counts sync latency after release
	logic        strapTaken;             // Strap address loaded

	// Address match helper, optionally checking the top nibble
	function automatic logic addrMatch(input logic [15:0] a, b,
		input logic qual);
		addrMatch = (a[11:0] == b[11:0])
			&& (!qual || (a[15:12] == 4'h0));
	endfunction : addrMatch

	// Base address inside the legal device window
	function automatic logic baseValid(input logic [15:0] b);
		baseValid = (b >= irqds_pkg::BASE_RANGE_LO)
			&& (b <= irqds_pkg::BASE_RANGE_HI);
	endfunction : baseValid

	// Reset value of a device's interrupt select
	function automatic logic [7:0] irqRst(input int d);
		irqRst = (d == 0) ? irqds_pkg::IRQ_SEL_RST_FLOPPY
			: irqds_pkg::IRQ_SEL_RST_OTHER;
	endfunction : irqRst

	// Reset value of a device's DMA select
	function automatic logic [7:0] dmaRst(input int d);
		dmaRst = (d == 0) ? irqds_pkg::DMA_SEL_RST_FLOPPY
			: irqds_pkg::DMA_SEL_RST_PAR;
	endfunction : dmaRst

	// Port decode
	wire        qual16   = oscCfg[irqds_pkg::OSC_QUAL16_BIT];
	wire [15:0] dataAddr = portAddr + 16'h0001;
	wire        hitIndex = addrMatch(ioAddr, portAddr, qual16);
	wire        hitData  = addrMatch(ioAddr, dataAddr, qual16);
	wire        wrIndex  = ioWr && hitIndex;
	wire        wrData   = ioWr && hitData;
	wire        cfgReset = hardReset || softReset;
	wire        isDevIdx = (indexReg >= 8'h30);
	wire        newPortBit0 = 1'b0;                                     // Even addresses only

	// Read data selection
	logic [7:0] rdSel;
	always_comb begin
		rdSel = 8'h00;
		case (indexReg)
			irqds_pkg::IDX_DEV_NUM:    rdSel = {5'h00, devNum};
			irqds_pkg::IDX_POWER_CTRL: rdSel = devOn;
			irqds_pkg::IDX_OSC_CFG:    rdSel = oscCfg;
			irqds_pkg::IDX_PORT_LOW:   rdSel = portAddr[7:0];
			irqds_pkg::IDX_PORT_HIGH:  rdSel = portAddr[15:8];
			irqds_pkg::IDX_ACTIVATE:   rdSel = {7'h00, devOn[devNum]};
			irqds_pkg::IDX_BASE_HIGH:  rdSel = baseAddr[devNum][15:8];
			irqds_pkg::IDX_BASE_LOW:   rdSel = baseAddr[devNum][7:0];
			irqds_pkg::IDX_IRQ_SEL:    rdSel = irqSelReg[devNum];
			irqds_pkg::IDX_DMA_SEL:    rdSel = dmaSelReg[devNum];
			default:                   rdSel = 8'h00;
		endcase
	end

	// Strap synchroniser; only the second stage is read
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strapMeta <= 1'b0;
			strapSync <= 1'b0;
		end else begin
			strapMeta <= config_port_strap;
			strapSync <= strapMeta;
		end
	end

	// Wait for the strap to pass the synchroniser before catching it
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			strapWait <= 2'h0;
		end else if (strapWait != 2'h3) begin
			strapWait <= strapWait + 2'h1;
		end
	end

	// Index register and global settings
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			indexReg   <= 8'h00;
			devNum     <= 3'h0;
			oscCfg     <= irqds_pkg::OSC_CFG_RST;
			portAddr   <= irqds_pkg::PORT_ADDR_STRAP0;
			strapTaken <= 1'b0;
		end else begin
			if (!strapTaken && (strapWait == 2'h3)) begin
				// Power-up location from the strap
				portAddr   <= strapSync ? irqds_pkg::PORT_ADDR_STRAP1
					: irqds_pkg::PORT_ADDR_STRAP0;
				strapTaken <= 1'b1;
			end else if (wrData && (indexReg == irqds_pkg::IDX_PORT_LOW)) begin
				portAddr[7:0] <= {ioWrData[7:1], newPortBit0};
			end else if (wrData && (indexReg == irqds_pkg::IDX_PORT_HIGH)) begin
				portAddr[15:8] <= ioWrData;
			end
			if (wrIndex) begin
				indexReg <= ioWrData;
			end
			if (cfgReset) begin
				devNum <= 3'h0;
			end else if (wrData && (indexReg == irqds_pkg::IDX_DEV_NUM)) begin
				devNum <= ioWrData[2:0];
			end
			if (hardReset) begin
				oscCfg <= irqds_pkg::OSC_CFG_RST;
			end else if (wrData && (indexReg == irqds_pkg::IDX_OSC_CFG)) begin
				oscCfg <= ioWrData;
			end
		end
	end

	// Per-device registers; every reset source restores the defaults
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			devOn <= 8'h00;
			for (int d = 0; d < irqds_pkg::NUM_DEV; d++) begin
				baseAddr[d]  <= 16'h0000;
				irqSelReg[d] <= irqRst(d);
				dmaSelReg[d] <= dmaRst(d);
			end
		end else if (cfgReset) begin
			devOn <= 8'h00;
			for (int d = 0; d < irqds_pkg::NUM_DEV; d++) begin
				baseAddr[d]  <= 16'h0000;
				irqSelReg[d] <= irqRst(d);
				dmaSelReg[d] <= dmaRst(d);
			end
		end else if (wrData) begin
			case (indexReg)
				irqds_pkg::IDX_POWER_CTRL: devOn <= ioWrData;
				irqds_pkg::IDX_ACTIVATE:   devOn[devNum] <= ioWrData[0];
				irqds_pkg::IDX_BASE_HIGH:  baseAddr[devNum][15:8] <= ioWrData;
				irqds_pkg::IDX_BASE_LOW:   baseAddr[devNum][7:0] <= ioWrData;
				irqds_pkg::IDX_IRQ_SEL:    irqSelReg[devNum] <= ioWrData;
				irqds_pkg::IDX_DMA_SEL:    dmaSelReg[devNum] <= ioWrData;
				default: ;
			endcase
		end
	end

	// Read data is registered; hit flags when the port answered
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			ioRdData <= 8'h00;
			ioRdHit  <= 1'b0;
		end else begin
			ioRdHit  <= ioRd && (hitIndex || hitData);
			if (ioRd && hitIndex) begin
				ioRdData <= indexReg;
			end else if (ioRd && hitData) begin
				ioRdData <= (isDevIdx || (indexReg <= irqds_pkg::IDX_PORT_HIGH))
					? rdSel : 8'h00;
			end
		end
	end

	// Configuration gate: active device with a legal base; keyboard needs only its activate bit
	wire [7:0] cfgOk;
	for (genvar g = 0; g < 8; g++) begin : gCfg
		if (g == 7) begin : gKbd
			assign cfgOk[g] = devOn[g];                    // Keyboard base is fixed
		end else begin : gRel
			assign cfgOk[g] = devOn[g] && baseValid(baseAddr[g]);
		end
	end

	// Selection validity
	wire [7:0] irqPicked;
	wire [7:0] dmaPicked;
	for (genvar g = 0; g < 8; g++) begin : gSel
		assign irqPicked[g] = irqSelReg[g][3:0] != irqds_pkg::IRQ_NONE;
		assign dmaPicked[g] = (dmaSelReg[g][2:0] >= irqds_pkg::DMA_CH_FIRST)
			&& (dmaSelReg[g][2:0] <= irqds_pkg::DMA_CH_LAST);
	end

	// Function-level gating
	wire floppyOk  = floppy_dma_irq_enable && !floppyPowerDown;
	wire ecpIrqOn  = (parallelEcrMode == irqds_pkg::ECR_MODE_FIFO)
		|| (parallelEcrMode == irqds_pkg::ECR_MODE_ECP)
		|| (parallelEcrMode == irqds_pkg::ECR_MODE_TEST);
	wire parIrqOk  = parallelEcpMode
		? ((ecpIrqOn || parallel_irq_enable) && !ecp_service_irq_bit)
		: parallel_irq_enable;
	wire parDmaOk  = parallelEcpMode && ecp_dma_enable_bit;
	wire ser1Ok    = (|uartIrqEnable1) && uart_aux_output_second[0];
	wire ser2Ok    = (|uartIrqEnable2) && uart_aux_output_second[1];

	// Router connection
	irqds_route_if rif ();

	// Raw requests and function enables laid out by device number
	wire [7:0] rawIrq = {kbdIrqReq, 1'b0, serialIrqReq[1], serialIrqReq[0],
		parallelIrqReq, 2'b00, floppyIrqReq};
	wire [7:0] rawDma = {4'h0, parallel_dma_request, 2'b00, floppyDmaReq};
	wire [7:0] fnIrqOk = {1'b1, 1'b0, ser2Ok, ser1Ok, parIrqOk, 2'b00, floppyOk};
	wire [7:0] fnDmaOk = {4'h0, parDmaOk, 2'b00, floppyOk};

	// Qualify each request by config, selection and function enable
	for (genvar g = 0; g < 8; g++) begin : gQual
		assign rif.irqSel[g]  = irqSelReg[g][3:0];
		assign rif.dmaSel[g]  = dmaSelReg[g][2:0];
		assign rif.irqQual[g] = rawIrq[g] && cfgOk[g]
			&& irqPicked[g] && fnIrqOk[g];
		assign rif.dmaQual[g] = rawDma[g] && cfgOk[g]
			&& dmaPicked[g] && fnDmaOk[g];
	end

	irqds_router uRouter (
		.clk_sys (clk_sys),
		.rst_n   (rst_n),
		.rt      (rif)
	);

	// Output drive; management interrupt is a separate active-low pin
	assign irqLines = rif.irqLines;
	assign dmaLines = rif.dmaLines;

	// Registered management interrupt; shares IRQ2 only by software care
	always_ff @(posedge clk_sys or negedge rst_n) begin
		if (!rst_n) begin
			system_mgmt_irq_n <= 1'b1;
		end else begin
			system_mgmt_irq_n <= !smiReq;
		end
	end

endmodule : irqds_top
`default_nettype wire

// ### irqds_top_assertions.sv
// Checker: port-level properties of the resource routing block
`timescale 1ns/1ps
`default_nettype none
module irqds_top_assertions (
	input wire logic        clk_sys, // Clock
	input wire logic        rst_n, // Reset, active low
	input wire logic        ioRd, // Read strobe
	input wire logic [7:0]  ioRdData, // Read data
	input wire logic        ioRdHit, // Read claimed
	input wire logic        floppy_dma_irq_enable, // Floppy D3
	input wire logic        floppyPowerDown, // Floppy off
	input wire logic        floppyIrqReq, // Floppy irq
	input wire logic        floppyDmaReq, // Floppy dma
	input wire logic        parallel_irq_enable, // Parallel D4
	input wire logic        parallelEcpMode, // Extended modes
	input wire logic        ecp_service_irq_bit, // Service bit
	input wire logic        ecp_dma_enable_bit, // Dma enable
	input wire logic        parallelIrqReq, // Parallel irq
	input wire logic        parallel_dma_request, // Parallel dma
	input wire logic [1:0]  uart_aux_output_second, // Aux outputs
	input wire logic [1:0]  serialIrqReq, // Serial irqs
	input wire logic        kbdIrqReq, // Keyboard irq
	input wire logic        smiReq, // Mgmt event
	input wire logic [15:1] irqLines, // Irq lines
	input wire logic        system_mgmt_irq_n, // Mgmt irq, low
	input wire logic [3:1]  dmaLines // Dma lines
);
	// One domain; reset cancels every attempt
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_n);
	// Config is unseen here, so irq and dma lines are checked only in the off direction
	wire fpOn = floppyIrqReq && floppy_dma_irq_enable && !floppyPowerDown;
	wire serOn = |(serialIrqReq & uart_aux_output_second);
	wire others = floppyIrqReq || |serialIrqReq || kbdIrqReq;
	wire quietPk = !parallelIrqReq && !kbdIrqReq;
	wire stdOff = !parallelEcpMode && !parallel_irq_enable;
	wire svcOn = parallelEcpMode && ecp_service_irq_bit;
	wire dmaOff = !(floppyDmaReq && floppy_dma_irq_enable && !floppyPowerDown)
		&& !(parallel_dma_request && parallelEcpMode && ecp_dma_enable_bit);

	a_idle_irq_off: assert property (!others && !parallelIrqReq |=> !irqLines)
		else $error("Irq with no request");
	a_idle_dma_off: assert property (!floppyDmaReq && !parallel_dma_request |=> !dmaLines)
		else $error("Dma with no request");
	a_floppy_gate: assert property (!fpOn && quietPk && !serialIrqReq |=> !irqLines)
		else $error("Gated floppy irq passed");
	a_serial_gate: assert property (!serOn && quietPk && !floppyIrqReq |=> !irqLines)
		else $error("Serial irq without aux output");
	a_par_std_gate: assert property (!others && stdOff |=> !irqLines)
		else $error("Parallel irq with enable clear");
	a_ecp_service: assert property (!others && svcOn |=> !irqLines)
		else $error("Parallel irq with service bit");
	a_dma_gate: assert property (dmaOff |=> !dmaLines)
		else $error("Dma without function enable");
	a_smi_low: assert property (smiReq |=> !system_mgmt_irq_n)
		else $error("Mgmt irq not low after event");
	a_smi_high: assert property (!smiReq |=> system_mgmt_irq_n)
		else $error("Mgmt irq low without event");
	a_rdhit_cause: assert property (ioRdHit |-> $past(ioRd))
		else $error("Read claim without read strobe");
	a_rddata_hold: assert property (!ioRdHit |-> $stable(ioRdData))
		else $error("Read data changed without claimed read");

	// Main scenarios reached
	c_irq6: cover property (irqLines[6]);
	c_dma3: cover property (dmaLines[3]);
	c_smi: cover property (!system_mgmt_irq_n);
	c_rdhit: cover property (ioRdHit);
endmodule : irqds_top_assertions
bind irqds_top irqds_top_assertions i_irqds_top_assertions (.*);
`default_nettype wire

// ### irqds_host_model.sv
// Partner model: host processor on the configuration port
`timescale 1ns/1ps
`default_nettype none
module irqds_host_model (
	input  wire logic        clk_sys, // System clock
	input  wire logic [7:0]  ioRdData, // Read data
	input  wire logic        ioRdHit, // Read claimed
	output var  logic [15:0] ioAddr, // I/O address
	output var  logic [7:0]  ioWrData, // Write data
	output var  logic        ioWr, // Write strobe
	output var  logic        ioRd // Read strobe
);
	logic [15:0] portAddr = 16'h002E; // Port the host believes in
	// Idle bus at time zero
	initial begin
		{ioAddr, ioWrData, ioWr, ioRd} = '0;
	end
	// Write held to its sampling edge, then inverted
	task automatic busWr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk_sys);
		ioAddr <= a;
		ioWrData <= d;
		ioWr <= 1'b1;
		@(posedge clk_sys);
		ioWr <= 1'b0;
		ioAddr <= ~a;
		ioWrData <= ~d;
	endtask : busWr
	// Read; registered answer taken mid-cycle
	task automatic busRd(input logic [15:0] a, output logic [7:0] d, output logic hit);
		@(posedge clk_sys);
		ioAddr <= a;
		ioRd <= 1'b1;
		@(posedge clk_sys);
		ioRd <= 1'b0;
		ioAddr <= ~a;
		@(negedge clk_sys);
		d = ioRdData;
		hit = ioRdHit;
	endtask : busRd
	// Index at the port, data at port plus one
	task automatic cfgWr(input logic [7:0] idx, d);
		busWr(portAddr, idx);
		busWr(portAddr + 16'h0001, d);
	endtask : cfgWr
	task automatic cfgRd(input logic [7:0] idx, output logic [7:0] d);
		logic h;
		busWr(portAddr, idx);
		busRd(portAddr + 16'h0001, d, h);
	endtask : cfgRd
endmodule : irqds_host_model
`default_nettype wire

// ### irqds_top_bench.sv
// Testbench: config accesses and request gating of the routing block
`timescale 1ns/1ps
`default_nettype none
module irqds_top_bench;
	logic        clk_sys, rst_n, hardReset, softReset, config_port_strap; // Clock, resets
	logic [15:0] ioAddr; // Host address
	logic [7:0]  ioWrData, ioRdData, rd; // Bus data, read-back
	logic        ioWr, ioRd, ioRdHit, hit; // Strobes, claim
	logic        floppy_dma_irq_enable, floppyPowerDown, floppyIrqReq, floppyDmaReq; // Floppy
	logic        parallel_irq_enable, parallelEcpMode, ecp_service_irq_bit; // Parallel
	logic        ecp_dma_enable_bit, parallelIrqReq, parallel_dma_request; // Parallel
	logic [2:0]  parallelEcrMode, dmaLines; // Mode, dma out
	logic [3:0]  uartIrqEnable1, uartIrqEnable2; // Serial enables
	logic [1:0]  uart_aux_output_second, serialIrqReq; // Serial
	logic        kbdIrqReq, smiReq, system_mgmt_irq_n; // Misc
	logic [15:1] irqLines; // Irq out
	int          errTotal = 0; // Mismatches
	int          totalChecks = 0; // Comparisons
	irqds_top i_irqds_top (.*); // Block under test
	irqds_host_model i_irqds_host_model (.*); // Host side
	// Free-running 10 MHz clock
	initial begin
		clk_sys = 1'b0;
		forever #50 clk_sys = ~clk_sys;
	end
	// Line vector for IRQ n, zero for none
	function automatic logic [15:1] irqBit(input int n);
		return (n == 0) ? 15'h0000 : 15'h0001 << (n - 1);
	endfunction : irqBit
	task automatic cmpReg(input string nm, input logic [7:0] exp, got);
		totalChecks++;
		if (got !== exp) begin
			errTotal++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : cmpReg
	// Lines are registered: one edge late
	task automatic cmpOut(input string nm, input logic [15:1] ei, input logic [3:1] ed);
		@(posedge clk_sys);
		@(negedge clk_sys);
		totalChecks++;
		if (irqLines !== ei || dmaLines !== ed) begin
			errTotal++;
			$display("[FAIL] %s expected %h/%h seen %h/%h", nm, ei, ed, irqLines, dmaLines);
		end
	endtask : cmpOut
	task automatic devWr(input logic [7:0] dev, idx, d);
		i_irqds_host_model.cfgWr(8'h07, dev);
		i_irqds_host_model.cfgWr(idx, d);
	endtask : devWr
	task automatic devChk(input logic [7:0] dev, idx, e);
		i_irqds_host_model.cfgWr(8'h07, dev);
		i_irqds_host_model.cfgRd(idx, rd);
		cmpReg("cfgData", e, rd);
	endtask : devChk
	// Reset six cycles; strap set long before sampling
	task automatic doReset(input logic strap);
		@(posedge clk_sys) rst_n <= 1'b0;
		config_port_strap <= strap;
		repeat (6) @(posedge clk_sys);
		rst_n <= 1'b1;
		repeat (6) @(posedge clk_sys);
		i_irqds_host_model.portAddr = strap ? 16'h004E : 16'h002E;
	endtask : doReset
	task automatic finalReport();
		$display("Checks %0d mismatches %0d", totalChecks, errTotal);
		if (errTotal == 0 && totalChecks > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask : finalReport
	// Watchdog: sequence needs about 600 cycles
	initial begin
		#1000000;
		errTotal++;
		finalReport();
	end
	// Main sequence
	initial begin
		{rst_n, hardReset, softReset, config_port_strap, smiReq, kbdIrqReq} = '0;
		{floppy_dma_irq_enable, floppyPowerDown, floppyIrqReq, floppyDmaReq} = '0;
		{parallel_irq_enable, parallelEcpMode, parallelEcrMode, ecp_service_irq_bit} = '0;
		{ecp_dma_enable_bit, parallelIrqReq, parallel_dma_request} = '0;
		{uartIrqEnable1, uartIrqEnable2, uart_aux_output_second, serialIrqReq} = '0;
		doReset(1'b0);
		devChk(8'h00, 8'h70, 8'h06);
		devChk(8'h00, 8'h74, 8'h02);
		devChk(8'h03, 8'h70, 8'h00);
		devChk(8'h03, 8'h74, 8'h04);
		devChk(8'h05, 8'h74, 8'h04);
		// Floppy at 0x3F0, active
		devWr(8'h00, 8'h60, 8'h03);
		devWr(8'h00, 8'h61, 8'hF0);
		devWr(8'h00, 8'h30, 8'h01);
		@(posedge clk_sys) floppyIrqReq <= 1'b1;
		cmpOut("fdcNoEn", 15'h0000, 3'h0);
		@(posedge clk_sys) floppy_dma_irq_enable <= 1'b1;
		cmpOut("fdcIrq", irqBit(6), 3'h0);
		@(posedge clk_sys) floppyDmaReq <= 1'b1;
		cmpOut("fdcDma", irqBit(6), 3'h2);
		@(posedge clk_sys) floppyPowerDown <= 1'b1;
		cmpOut("fdcDown", 15'h0000, 3'h0);
		@(posedge clk_sys) floppyPowerDown <= 1'b0;
		// All selects; mgmt event off for IRQ2
		for (int n = 0; n < 16; n++) begin
			devWr(8'h00, 8'h70, 8'(n));
			cmpOut("irqSel", irqBit(n), 3'h2);
		end
		for (int c = 0; c < 8; c++) begin
			devWr(8'h00, 8'h74, 8'(c));
			cmpOut("dmaSel", irqBit(15), (c >= 1 && c <= 3) ? 3'(3'h1 << (c - 1)) : 3'h0);
		end
		// Serial 1 shares IRQ6 with the floppy
		devWr(8'h00, 8'h70, 8'h06);
		devWr(8'h04, 8'h60, 8'h03);
		devWr(8'h04, 8'h61, 8'hF8);
		devWr(8'h04, 8'h70, 8'h06);
		devWr(8'h04, 8'h30, 8'h01);
		@(posedge clk_sys) {floppyIrqReq, serialIrqReq, uartIrqEnable1} <= {1'b0, 2'h1, 4'h8};
		cmpOut("serNoAux", 15'h0000, 3'h0);
		@(posedge clk_sys) uart_aux_output_second <= 2'h1;
		cmpOut("serIrq", irqBit(6), 3'h0);
		@(posedge clk_sys) {floppyIrqReq, serialIrqReq} <= {1'b1, 2'h0};
		cmpOut("shared", irqBit(6), 3'h0);
		@(posedge clk_sys) {floppyIrqReq, serialIrqReq, uartIrqEnable1} <= {1'b0, 2'h1, 4'h0};
		cmpOut("serNoIer", 15'h0000, 3'h0);
		@(posedge clk_sys) serialIrqReq <= 2'h0;
		// Parallel at 0x378 on IRQ7, DMA3
		devWr(8'h03, 8'h60, 8'h03);
		devWr(8'h03, 8'h61, 8'h78);
		devWr(8'h03, 8'h70, 8'h07);
		devWr(8'h03, 8'h74, 8'h03);
		devWr(8'h03, 8'h30, 8'h01);
		@(posedge clk_sys) parallelIrqReq <= 1'b1;
		cmpOut("parNoEn", 15'h0000, 3'h0);
		@(posedge clk_sys) parallel_irq_enable <= 1'b1;
		cmpOut("parIrq", irqBit(7), 3'h0);
		@(posedge clk_sys) {parallelEcpMode, parallel_irq_enable} <= 2'b10;
		for (int m = 0; m < 8; m++) begin
			@(posedge clk_sys) parallelEcrMode <= 3'(m);
			cmpOut("ecpMode", (m == 2 || m == 3 || m == 6) ? irqBit(7) : 15'h0000, 3'h0);
		end
		@(posedge clk_sys) {parallelEcrMode, ecp_service_irq_bit} <= {3'h3, 1'b1};
		cmpOut("ecpSvc", 15'h0000, 3'h0);
		@(posedge clk_sys) parallel_dma_request <= 1'b1;
		cmpOut("ecpNoDma", 15'h0000, 3'h0);
		@(posedge clk_sys) ecp_dma_enable_bit <= 1'b1;
		cmpOut("ecpDma", 15'h0000, 3'h4);
		devWr(8'h07, 8'h70, 8'h01);
		devWr(8'h07, 8'h30, 8'h01);
		@(posedge clk_sys) kbdIrqReq <= 1'b1;
		cmpOut("kbdIrq", irqBit(1), 3'h4);
		@(posedge clk_sys) smiReq <= 1'b1;
		@(posedge clk_sys);
		@(negedge clk_sys);
		cmpReg("smiN", 8'h00, {7'h00, system_mgmt_irq_n});
		@(posedge clk_sys) smiReq <= 1'b0;
		// Move the port to 0x0200, high byte first
		i_irqds_host_model.cfgWr(8'h27, 8'h02);
		i_irqds_host_model.portAddr = 16'h022E;
		i_irqds_host_model.cfgWr(8'h26, 8'h00);
		i_irqds_host_model.portAddr = 16'h0200;
		i_irqds_host_model.busWr(16'h1200, 8'h07);
		i_irqds_host_model.busRd(16'h1201, rd, hit);
		cmpReg("alias12", 8'h01, {7'h00, hit});
		i_irqds_host_model.cfgWr(8'h24, 8'h40);
		i_irqds_host_model.busRd(16'h1201, rd, hit);
		cmpReg("qual16", 8'h00, {7'h00, hit});
		i_irqds_host_model.busRd(16'h002F, rd, hit);
		cmpReg("oldPort", 8'h00, {7'h00, hit});
		// Soft reset restores selects, drops devices
		devWr(8'h00, 8'h70, 8'h0B);
		@(posedge clk_sys) softReset <= 1'b1;
		@(posedge clk_sys) softReset <= 1'b0;
		cmpOut("softOff", 15'h0000, 3'h0);
		devChk(8'h00, 8'h70, 8'h06);
		devChk(8'h00, 8'h74, 8'h02);
		i_irqds_host_model.cfgWr(8'h22, 8'h08);
		devChk(8'h03, 8'h30, 8'h01);
		@(posedge clk_sys) hardReset <= 1'b1;
		@(posedge clk_sys) hardReset <= 1'b0;
		devChk(8'h00, 8'h24, 8'h00);
		doReset(1'b1);
		devChk(8'h00, 8'h70, 8'h06);
		finalReport();
	end
endmodule : irqds_top_bench
`default_nettype wire
